// File: src/ftx_encoder.sv
// transmit coding path: buffer, 4b5b, scrambler, nrzi, mlt-3
// How it works
// R1 - every MAC nibble becomes a 5-bit code-group before going out
// R2 - data nibbles map through the fixed sixteen-entry code-group table
// R3 - first preamble byte of each frame is sent as J then K
// R4 - later preamble and data nibbles are encoded while the frame lasts
// R5 - enable low ends the frame; encoder then sends T then R
// R6 - after R, IDLE code-groups go out until enable rises again
// R7 - halt code-group marks errors, distinct from all data codes
// R8 - invalid code-groups are never emitted
// R9 - scrambler is an 11-bit self-feeding LFSR running continuously
// R10 - polynomial x^11 + x^9 + 1, one step per serial bit
// R11 - each serial bit is XORed with the scrambler output
// R12 - scrambler seed comes from the five address straps
// R13 - scrambling can be bypassed
// R14 - NRZI: a one toggles the line level, a zero holds it
// R15 - NRZI split into two streams with alternating one events
// R16 - only MLT-3 output; no plain binary output exists
// R17 - MII nibbles become a serial scrambled MLT-3 stream
// R18 - frame sequencing follows the standard transmit state machine
`timescale 1ns/100ps
`default_nettype none

module ftx_fifo
	import ftx_pkg::*;
#(
	parameter int W     = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         resetn,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	logic         push;
	logic         pop;

	assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data  = mem[rd_q[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage
	always_ff @(posedge mclk) begin
		if (push) begin
			mem[wr_q[AW-1:0]] <= in_data;
		end
	end

	// pointers
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule // ftx_fifo

module ftx_encoder
	import ftx_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	// clock and reset
	input  wire logic       mclk,
	input  wire logic       resetn,
	// mac side
	input  wire logic       mii_valid,
	output logic            mii_ready,
	input  wire logic       tx_en,
	input  wire logic       tx_er,
	input  wire logic [3:0] txd,
	// configuration
	input  wire logic [4:0] phy_address_straps,
	input  wire logic       scrambler_bypass,
	// line side
	output logic            line_pos,
	output logic            line_neg,
	output logic            frame_active
);
	ftx_word_t   in_word;
	ftx_word_t   head;
	logic        head_valid;
	logic        pop;
	logic        load;
	ftx_state_t  state_q;
	ftx_state_t  state_d;
	logic [4:0]  cg_d;
	logic [4:0]  shift_q;
	logic [2:0]  cnt_q;
	logic [SCR_W-1:0] scr_q;
	logic        scr_bit;
	logic        sbit;
	logic        nrzi_q;
	logic        nrzi_d;
	logic [1:0]  phase_q;
	logic [1:0]  phase_d;
	logic        pos_q;
	logic        neg_q;

	assign in_word = '{en: tx_en, er: tx_er, nib: txd};

	// mac nibble buffer
	ftx_fifo #(
		.W     (WORD_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.mclk      (mclk),
		.resetn    (resetn),
		.in_valid  (mii_valid),
		.in_ready  (mii_ready),
		.in_data   (in_word),
		.out_valid (head_valid),
		.out_ready (pop),
		.out_data  (head)
	);

	assign load = cnt_q == CG_LAST;

	// code-group selection and frame sequencing
	always_comb begin
		state_d = state_q;
		cg_d    = CG_IDLE;
		pop     = 1'b0;
		case (state_q) // R18
			ST_IDLE: begin
				if (head_valid && head.en) begin
					pop     = load;
					cg_d    = CG_J; // R3
					state_d = ST_K;
				end else begin
					pop     = load && head_valid;
					cg_d    = CG_IDLE; // R6
				end
			end
			ST_K: begin
				pop     = load && head_valid && head.en;
				cg_d    = CG_K; // R3
				state_d = ST_DATA;
			end
			ST_DATA: begin
				if (!head_valid) begin
					cg_d = CG_HALT; // R7
				end else if (head.en) begin
					pop  = load;
					if (head.er) begin
						cg_d = CG_HALT; // R7
					end else begin
						cg_d = ENC_TABLE[head.nib]; // R1 R2 R4
					end
				end else begin
					pop     = load;
					cg_d    = CG_T; // R5
					state_d = ST_R;
				end
			end
			ST_R: begin
				cg_d    = CG_R; // R5
				state_d = ST_IDLE;
			end
			default: begin
				cg_d    = CG_IDLE;
				state_d = ST_IDLE;
			end
		endcase
	end

	// sequencer state, advances once per code-group
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
		end else if (load) begin
			state_q <= state_d;
		end
	end

	// serializer, msb of code-group first; only table and control codes load
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			shift_q <= CG_IDLE;
			cnt_q   <= CNT_RST;
		end else if (load) begin
			shift_q <= cg_d; // R8
			cnt_q   <= CNT_RST;
		end else begin
			shift_q <= {shift_q[3:0], 1'b0};
			cnt_q   <= cnt_q + 3'h1;
		end
	end

	// scrambler, seeded from straps during reset
	assign scr_bit = scr_q[SCR_TAP_A] ^ scr_q[SCR_TAP_B]; // R10
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			scr_q <= {1'b1, phy_address_straps, ~phy_address_straps}; // R12
		end else begin
			scr_q <= {scr_q[SCR_W-2:0], scr_bit}; // R9 R10
		end
	end

	assign sbit = scrambler_bypass ? shift_q[CG_W-1] : // R13
		shift_q[CG_W-1] ^ scr_bit; // R11

	// nrzi level
	assign nrzi_d = nrzi_q ^ sbit; // R14
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			nrzi_q <= 1'b0;
		end else begin
			nrzi_q <= nrzi_d;
		end
	end

	// mlt-3 phase steps on every nrzi transition
	assign phase_d = (nrzi_d != nrzi_q) ? phase_q + 2'h1 : phase_q; // R15
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			phase_q <= MLT_RST;
			pos_q   <= 1'b0;
			neg_q   <= 1'b0;
		end else begin
			phase_q <= phase_d;
			pos_q   <= phase_d == MLT_POS; // R15
			neg_q   <= phase_d == MLT_NEG; // R15
		end
	end

	// frame indication
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			frame_active <= 1'b0;
		end else if (load) begin
			frame_active <= state_d != ST_IDLE;
		end
	end

	// only the two mlt-3 halves reach the line
	assign line_pos = pos_q; // R16 R17
	assign line_neg = neg_q; // R16
endmodule // ftx_encoder

`default_nettype wire

// File: common/ftx_pkg.sv
// shared constants and types of the fast ethernet transmit encoder
package ftx_pkg;

	// code-group bits and serial slot
	localparam int          CG_W      = 5;
	localparam logic [2:0]  CG_LAST   = 3'h4;
	localparam logic [2:0]  CNT_RST   = 3'h0;

	// control code-groups
	localparam logic [4:0]  CG_IDLE   = 5'h1F;
	localparam logic [4:0]  CG_J      = 5'h18;
	localparam logic [4:0]  CG_K      = 5'h11;
	localparam logic [4:0]  CG_T      = 5'h0D;
	localparam logic [4:0]  CG_R      = 5'h07;
	localparam logic [4:0]  CG_HALT   = 5'h04;

	// scrambler
	localparam int          SCR_W     = 11;
	localparam int          SCR_TAP_A = 10;
	localparam int          SCR_TAP_B = 8;

	// line coder reset and phase values
	localparam logic [1:0]  MLT_RST   = 2'h0;
	localparam logic [1:0]  MLT_POS   = 2'h1;
	localparam logic [1:0]  MLT_NEG   = 2'h3;

	// buffer defaults
	localparam int          FIFO_DEPTH = 32;

	// nibble to code-group table
	localparam logic [4:0] ENC_TABLE [16] = '{
		5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
		5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D
	};

	// one buffered MII transfer
	typedef struct packed {
		logic       en;
		logic       er;
		logic [3:0] nib;
	} ftx_word_t;

	localparam int WORD_W = $bits(ftx_word_t);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_K,
		ST_DATA,
		ST_R
	} ftx_state_t;

endpackage

// File: dv/ftx_checker.sv
// port checker for the transmit encoder
`timescale 1ns/100ps
`default_nettype none
module ftx_checker (
	// clock and reset
	input wire logic mclk,
	input wire logic resetn,
	// watched ports
	input wire logic mii_ready,
	input wire logic scrambler_bypass,
	input wire logic line_pos,
	input wire logic line_neg,
	input wire logic frame_active
);
	logic lp_q;
	always_ff @(posedge mclk)
		lp_q <= !resetn ? 1'b0 : line_pos ? 1'b1 : line_neg ? 1'b0 : lp_q;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_ex; !(line_pos && line_neg); endproperty
	a_ex: assert property (p_ex) else $error("both high");
	property p_ap; $rose(line_pos) |-> !lp_q; endproperty
	a_ap: assert property (p_ap) else $error("pos twice");
	property p_an; $rose(line_neg) |-> lp_q; endproperty
	a_an: assert property (p_an) else $error("neg twice");
	property p_pn; $rose(line_pos) |-> !$past(line_neg); endproperty
	a_pn: assert property (p_pn) else $error("neg to pos");
	property p_np; $rose(line_neg) |-> !$past(line_pos); endproperty
	a_np: assert property (p_np) else $error("pos to neg");
	property p_idle;
		$past(resetn, 5) && !frame_active && !$past(frame_active, 3) &&
		scrambler_bypass && $past(scrambler_bypass, 3) |->
		line_pos != $past(line_pos) || line_neg != $past(line_neg);
	endproperty
	a_idle: assert property (p_idle) else $error("idle gap");
	property p_fh; $changed(frame_active) |=> $stable(frame_active)[*4];
	endproperty
	a_fh: assert property (p_fh) else $error("mid slot");
	property p_fl; $rose(frame_active) |-> ##14 frame_active; endproperty
	a_fl: assert property (p_fl) else $error("short frame");
	c_fr: cover property ($rose(frame_active));
	c_fu: cover property (!mii_ready);
	c_ng: cover property ($rose(line_neg));
endmodule // ftx_checker
bind ftx_encoder ftx_checker i_ftx_checker (.mclk, .resetn, .mii_ready,
	.scrambler_bypass, .line_pos, .line_neg, .frame_active);
`default_nettype wire

// File: dv/ftx_mac_model.sv
// mac model feeding words into the encoder
`timescale 1ns/100ps
`default_nettype none
module ftx_mac_model
	import ftx_pkg::*;
(
	// clock and flow
	input  wire logic mclk,
	input  wire logic mii_ready,
	input  wire logic gap,
	output logic      mii_valid,
	output ftx_word_t w
);
	ftx_word_t q[$];
	logic      tk;
	initial begin
		mii_valid = 0;
		w = '0;
		tk = 0;
	end
	task push(input ftx_word_t x);
		q.push_back(x);
	endtask
	// word held until taken
	always @(posedge mclk) begin
		tk = mii_valid && mii_ready;
		if (tk)
			void'(q.pop_front());
	end
	always @(negedge mclk) begin
		mii_valid = q.size() != 0 && !(gap && tk);
		w = mii_valid ? q[0] : ~w;
	end
endmodule // ftx_mac_model
`default_nettype wire

// File: dv/tb_ftx_encoder.sv
// testbench for the transmit encoder
`timescale 1ns/100ps
`default_nettype none
module tb_ftx_encoder
	import ftx_pkg::*;
;
	localparam logic [4:0] TC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15,
		5'h0A, 5'h0B, 5'h0E, 5'h0F, 5'h12, 5'h13, 5'h16, 5'h17,
		5'h1A, 5'h1B, 5'h1C, 5'h1D};
	logic mclk = 0, resetn = 0, byp = 1, gap = 0, mv, rdy, lp, ln, fa;
	logic full = 0, col = 0, sc = 0, fh = 0;
	logic [1:0] pv = 0;
	logic [4:0] pa = 5'h0B;
	logic [11:0] h = 0;
	logic [9:0] sh = 0;
	logic [4:0] got[$];
	int k, failures = 0, tests_run = 0;
	ftx_word_t w;
	ftx_encoder i_ftx_encoder (.mclk, .resetn, .mii_valid(mv),
		.mii_ready(rdy), .tx_en(w.en), .tx_er(w.er), .txd(w.nib),
		.phy_address_straps(pa), .scrambler_bypass(byp),
		.line_pos(lp), .line_neg(ln), .frame_active(fa));
	ftx_mac_model i_ftx_mac_model (.mclk, .mii_ready(rdy), .gap,
		.mii_valid(mv), .w);
	initial forever #50 mclk = !mclk;
	task chk(input string n, input logic [4:0] e, input logic [4:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	// line decoder: any pin change is a one
	always @(posedge mclk) begin
		h = {h[10:0], {lp, ln} != pv};
		pv = {lp, ln};
		if (sc) chk("scr", {4'h0, ~(h[11] ^ h[9])}, h[4:0] & 5'h01);
		sh = {sh[8:0], h[0]};
		if (col)
			k++;
		if (col && k == 5) begin
			got.push_back(sh[4:0]);
			k = 0;
			col = sh[4:0] != 5'h07;
		end else if (!col && sh == 10'h311) begin
			col = 1;
			k = 0;
		end
		if (!rdy) full = 1;
		if (fa) fh = 1;
	end
	task t_frame(input logic g);
		logic [4:0] e[$];
		gap = g;
		full = 0;
		fh = 0;
		got = {};
		e = {};
		for (int i = 0; i < 59; i++) begin
			i_ftx_mac_model.push({1'b1, i == 18, i < 2 ? 4'h5 : 4'(i - 2)});
			if (i > 1) e.push_back(i == 18 ? 5'h04 : TC[(i - 2) % 16]);
		end
		i_ftx_mac_model.push('0);
		e.push_back(5'h0D);
		e.push_back(5'h07);
		for (int n = 0; n < 900 && got.size() < e.size(); n++)
			@(negedge mclk);
		repeat (10) @(negedge mclk);
		foreach (e[i]) chk("cg", e[i], got.size() > i ? got[i] : 'x);
		chk("full", 5'h01, {4'h0, full});
		chk("fa", 5'h00, {4'h0, fa});
		chk("fh", 5'h01, {4'h0, fh});
	endtask
	task t_scr;
		logic [11:0] hs;
		byp = 0;
		repeat (20) @(negedge mclk);
		sc = 1;
		repeat (200) @(negedge mclk);
		sc = 0;
		// same span after reset, two strap values, streams must differ
		for (int s = 0; s < 2; s++) begin
			pa = s ? 5'h14 : 5'h0B;
			resetn = 0;
			repeat (2) @(negedge mclk);
			resetn = 1;
			repeat (16) @(negedge mclk);
			if (s) chk("seed", 5'h01, {4'h0, h != hs});
			hs = h;
		end
	endtask
	task results;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(negedge mclk);
		chk("rst", 5'h01, {1'b0, lp, ln, fa, rdy});
		resetn = 1;
		t_frame(0);
		t_frame(1);
		t_scr;
		results;
	end
	initial begin
		repeat (6000) @(posedge mclk);
		failures++;
		results;
	end
endmodule // tb_ftx_encoder
`default_nettype wire
